// File: testbench/rxa_line_model.sv
`timescale 1ns/10ps
module rxa_line_model #(
  parameter bit HM = 1'b0
) (
  input wire logic go_i,
  input wire logic [15:0] nfr_i,
  input wire logic [15:0] len_i,
  output logic clk_o,
  output logic data_o,
  output logic fp_n_o,
  output logic busy_o
);
  int f;
  int j;
  initial begin
    clk_o = 1'b0;
    data_o = 1'b0;
    fp_n_o = 1'b1;
    busy_o = 1'b0;
    forever begin
      @(posedge go_i);
      busy_o = 1'b1;
      #13;
      // clock period of 200 ns, 400 ns per bit in HM, keeps every link under its rate limit.
      for (f = 0; f < nfr_i; f++) begin
        #50 fp_n_o = !HM;
        #50 clk_o = HM;
        #100 clk_o = 1'b0;
        for (j = 0; j < len_i; j++) begin
          data_o = ^(j & 16'h0029);
          repeat (HM + 1) begin
            #50 fp_n_o = 1'b1;
            #50 clk_o = 1'b1;
            #100 clk_o = 1'b0;
          end
        end
      end
      // The clock stands still and the line no longer shows the last bit.
      data_o = !data_o;
      busy_o = 1'b0;
    end
  end
endmodule // rxa_line_model

// File: testbench/tb_rxa_top.sv
`timescale 1ns/10ps
`include "rxa_regs.svh"
`define CHECK_EQ(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module tb_rxa_top;
  logic core_clk_i;
  logic rstn_i;
  rxa_pkg::rxa_link_cfg_t [`RXA_LINKS-1:0] cfg;
  rxa_pkg::rxa_bit_t rx_bit;
  rxa_pkg::rxa_bit_t q[`RXA_LINKS][$];
  int qc[`RXA_LINKS][$];
  logic c0, d0, b0, c1, d1, f1, b1, dsel;
  logic [1:0] go;
  logic [15:0] nfr;
  logic [15:0] len;
  int cyc;
  int err_count;
  int n_tests;

  rxa_top uut (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .link_cfg_i(cfg),
    .rx_line_clock_i({`RXA_LINKS{c0}}),
    .rx_line_data_i({`RXA_LINKS{dsel ? d1 : d0}}),
    .rx_group_data_clock_i({`RXA_GROUPS{c1}}),
    .rx_group_frame_pulse_n_i({`RXA_GROUPS{f1}}),
    .rx_highrate_data_clock_i(c1),
    .rx_highrate_frame_pulse_n_i(f1),
    .rx_highrate_frame_pulse_clock_i(c1),
    .rx_bit_o(rx_bit)
  );
  rxa_line_model #(.HM(1'b0)) line_src (.go_i(go[0]), .nfr_i(nfr), .len_i(len), .clk_o(c0), .data_o(d0),
    .fp_n_o(), .busy_o(b0));
  rxa_line_model #(.HM(1'b1)) bus_src (.go_i(go[1]), .nfr_i(nfr), .len_i(len), .clk_o(c1), .data_o(d1),
    .fp_n_o(f1), .busy_o(b1));

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // Outputs are collected mid-cycle, where they have settled.
  always @(negedge core_clk_i) begin
    cyc++;
    if (rx_bit.valid === 1'b1) begin
      q[rx_bit.link].push_back(rx_bit);
      qc[rx_bit.link].push_back(cyc);
    end
    if (cyc == 60000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic do_reset(input logic [95:0] c, input logic s);
    #2 rstn_i = 1'b0;
    cfg = c;
    dsel = s;
    repeat (6) @(posedge core_clk_i);
    #2 rstn_i = 1'b1;
    foreach (q[l]) begin
      q[l].delete();
      qc[l].delete();
    end
  endtask

  // Runs whole frames from one source, then lets the pipeline drain.
  task automatic run(input int m, input logic [15:0] n, input logic [15:0] ln);
    nfr = n;
    len = ln;
    go[m] = 1'b1;
    @(posedge core_clk_i);
    #2 go[m] = 1'b0;
    wait ((m ? b1 : b0) === 1'b0);
    repeat (12) @(posedge core_clk_i);
  endtask

  task automatic chk_link(input int l, input int fb, input int first, input int n, input bit al);
    int i;
    int k;
    i = 0;
    while (al && i < q[l].size() && q[l][i].frame_start !== 1'b1) i++;
    `CHECK_EQ("bit count", n, q[l].size() - i)
    for (k = 0; k < n && i + k < q[l].size(); k++) begin
      `CHECK_EQ("data", ^(k % len & 16'h0029), q[l][i + k].data)
      `CHECK_EQ("slot", first + (k % fb) / 8, q[l][i + k].slot)
      `CHECK_EQ("bitpos", k % 8, q[l][i + k].bitpos)
      `CHECK_EQ("frame start", al && (k % fb == 0), q[l][i + k].frame_start)
    end
  endtask

  function automatic int others(input logic [31:0] keep);
    int s;
    s = 0;
    for (int l = 0; l < `RXA_LINKS; l++) if (!keep[l]) s += q[l].size();
    return s;
  endfunction

  // Link 0 T1, link 1 E1, link 2 unchannelised, the rest low-rate bus mode.
  task automatic t_chan();
    logic [95:0] c;
    c = {`RXA_LINKS{3'h6}};
    c[2:0] = 3'h0;
    c[5:3] = 3'h1;
    c[8:6] = 3'h2;
    do_reset(c, 1'b0);
    run(0, 16'h0002, 16'h00c0);
    chk_link(0, 192, 0, 192, 1'b1);
    chk_link(1, 192, 1, 192, 1'b1);
    chk_link(2, 1024, 0, 384, 1'b0);
    `CHECK_EQ("link1 after link0", 1, qc[1][$] - qc[0][$])
    `CHECK_EQ("link2 after link1", 1, qc[2][$] - qc[1][$])
    `CHECK_EQ("silent links", 0, others(32'h0000_0007))
    $display("test chan done");
  endtask

  task automatic t_low_rate();
    do_reset({{24{3'h0}}, {8{3'h6}}}, 1'b1);
    run(1, 16'h0002, 16'h0100);
    for (int l = 0; l < 8; l++) chk_link(l, 256, 0, 512, 1'b1);
    `CHECK_EQ("silent links", 0, others(32'h0000_00ff))
    $display("test low rate done");
  endtask

  task automatic t_high_rate();
    logic [95:0] c;
    c = {`RXA_LINKS{3'h0}};
    c[14:12] = 3'h4;
    c[17:15] = 3'h4;
    c[26:24] = 3'h4;
    do_reset(c, 1'b1);
    run(1, 16'h0002, 16'h0400);
    chk_link(4, 1024, 0, 2048, 1'b1);
    chk_link(8, 1024, 0, 2048, 1'b1);
    `CHECK_EQ("silent links", 0, others(32'h0000_0110))
    $display("test high rate done");
  endtask

  initial begin
    rstn_i = 1'b0;
    cfg = '0;
    dsel = 1'b0;
    go = 2'h0;
    nfr = 16'h0000;
    len = 16'h0000;
    cyc = 0;
    err_count = 0;
    n_tests = 0;
    t_chan();
    t_low_rate();
    t_high_rate();
    give_verdict();
  end
endmodule // tb_rxa_top

// File: verilog/rxa_pkg.sv
`include "rxa_regs.svh"

package rxa_pkg;

  // Reception mode of one link.
  typedef enum logic [1:0] {
    RXA_CHAN = 2'h0,
    RXA_UNCH = 2'h1,
    RXA_H8 = 2'h2,
    RXA_H2 = 2'h3
  } rxa_mode_t;

  typedef struct packed {
    rxa_mode_t mode;
    logic e1;
  } rxa_link_cfg_t;

  // One received bit, handed out in priority order.
  typedef struct packed {
    logic valid;
    logic [4:0] link;
    logic data;
    logic [6:0] slot;
    logic [2:0] bitpos;
    logic frame_start;
  } rxa_bit_t;

  typedef struct packed {
    logic [2:0][`RXA_SYNC_W-1:0] sy;
    logic [`RXA_EDGE_W-1:0] lvl;
    logic [`RXA_LINKS-1:0][7:0] icnt;
    logic [`RXA_LINKS-1:0][7:0] ival;
    logic [`RXA_LINKS-1:0][6:0] slot;
    logic [`RXA_LINKS-1:0][2:0] bpos;
    logic [`RXA_LINKS-1:0] fsp;
    logic [`RXA_GROUPS-1:0] gph;
    logic hph;
    logic [`RXA_LINKS-1:0] pend;
    logic [`RXA_LINKS-1:0] pdat;
    logic [`RXA_LINKS-1:0][6:0] pslot;
    logic [`RXA_LINKS-1:0][2:0] pbpos;
    logic [`RXA_LINKS-1:0] pfs;
    rxa_bit_t out;
  } rxa_state_t;

endpackage

// File: verilog/rxa_regs.svh
`ifndef RXA_REGS_SVH
`define RXA_REGS_SVH

// Link population and grouping.
`define RXA_LINKS 32
`define RXA_GROUPS 4
`define RXA_GROUP_SIZE 8
`define RXA_HR_STEP 4

// Bit positions of the pin vector that enters the synchroniser.
`define RXA_SYNC_W 75
`define RXA_SY_CLK 0
`define RXA_SY_DAT 32
`define RXA_SY_GCK 64
`define RXA_SY_GFP 68
`define RXA_SY_HDC 72
`define RXA_SY_HFP 73
`define RXA_SY_HFC 74

// Bit positions of the clock-only vector used for edge detection.
`define RXA_EDGE_W 38
`define RXA_ED_GCK 32
`define RXA_ED_HDC 36
`define RXA_ED_HFC 37

// Time-slot numbering per framing.
`define RXA_SLOT_ZERO 7'h00
`define RXA_T1_LAST 7'h17
`define RXA_E1_FIRST 7'h01
`define RXA_E1_LAST 7'h1f
`define RXA_H2_LAST 7'h1f
`define RXA_H8_LAST 7'h7f
`define RXA_UNCH_LAST 7'h7f
`define RXA_BIT_LAST 3'h7

// Saturation of the per-link interval counter, in core cycles.
`define RXA_ICNT_MAX 8'hff

`endif

// File: verilog/rxa_top.sv
`timescale 1ns/10ps
`include "rxa_regs.svh"

// Overview of operation
// - Low-rate H-MVIP: sample each group of eight on every second group clock rise.
// - High-rate H-MVIP: sample links 4m on every second high-rate data clock rise.
// - H-MVIP links carry 32 slots at low rate, 128 at high rate.
// - Channelised links carry 24 slots for T1/J1, 31 slots for E1.
// - Channelised slot alignment comes from the position of the clock gap.
// - Channelised and unchannelised data is captured on the link clock rise.
// - Links 3 to 31 run up to 10 Mbit/s, links 0 to 2 up to 51.84.
// - Group clock k serves links 8k through 8k+7 at the low H-MVIP rate.
// - A group clock is ignored when no link of its group uses low-rate H-MVIP.
// - Group frame pulse k aligns frames on links 8k through 8k+7.
// - Group frame pulse is sampled on the group clock fall, else ignored.
// - Only links 0, 4, ..., 28 may run high-rate H-MVIP.
// - High-rate frame pulse is sampled on the frame pulse clock fall, else ignored.
// - The frame pulse clock is ignored when no link runs high-rate H-MVIP.
// - The high-rate data clock is ignored when no link runs high-rate H-MVIP.
// - A link's own clock is invalid and unused while the link runs H-MVIP.
// - Received bits are serviced by fixed priority, link 0 highest.
module rxa_top (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire rxa_pkg::rxa_link_cfg_t [`RXA_LINKS-1:0] link_cfg_i,
  input wire logic [`RXA_LINKS-1:0] rx_line_clock_i,
  input wire logic [`RXA_LINKS-1:0] rx_line_data_i,
  input wire logic [`RXA_GROUPS-1:0] rx_group_data_clock_i,
  input wire logic [`RXA_GROUPS-1:0] rx_group_frame_pulse_n_i,
  input wire logic rx_highrate_data_clock_i,
  input wire logic rx_highrate_frame_pulse_n_i,
  input wire logic rx_highrate_frame_pulse_clock_i,
  output rxa_pkg::rxa_bit_t rx_bit_o
);

  rxa_pkg::rxa_state_t st_reg;
  rxa_pkg::rxa_state_t st_next;

  logic [`RXA_SYNC_W-1:0] pins;
  logic [`RXA_SYNC_W-1:0] s2;
  logic [`RXA_SYNC_W-1:0] s3;
  logic [`RXA_EDGE_W-1:0] cs2;
  logic [`RXA_EDGE_W-1:0] cs3;
  logic [`RXA_EDGE_W-1:0] chg;
  logic [`RXA_EDGE_W-1:0] rise;
  logic [`RXA_EDGE_W-1:0] fall;
  logic [`RXA_GROUPS-1:0] g_en;
  logic hr_en;
  logic [`RXA_GROUPS-1:0] gsamp;
  logic [`RXA_GROUPS-1:0] gfp_ev;
  logic hsamp;
  logic hfp_ev;
  logic [`RXA_LINKS-1:0] samp;
  logic [`RXA_LINKS-1:0] align;
  logic [`RXA_LINKS-1:0] gap;
  logic [`RXA_LINKS-1:0][6:0] first;
  logic [`RXA_LINKS-1:0][6:0] last;
  logic [4:0] grant;

  // True when any link of a group of eight runs low-rate H-MVIP.
  function automatic logic group_uses_h2(input rxa_pkg::rxa_link_cfg_t [`RXA_GROUP_SIZE-1:0] cfg);
    logic hit;
    hit = 1'b0;
    for (int j = 0; j < `RXA_GROUP_SIZE; j++) begin
      if (cfg[j].mode == rxa_pkg::RXA_H2) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Index of the lowest set bit; zero when none is set.
  function automatic logic [4:0] lowest(input logic [`RXA_LINKS-1:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = `RXA_LINKS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // First and last time-slot number of a link's frame, by mode and framing.
  function automatic logic [13:0] bounds(input rxa_pkg::rxa_link_cfg_t cfg);
    logic [13:0] b;
    unique case (cfg.mode)
      rxa_pkg::RXA_CHAN: b = cfg.e1 ? {`RXA_E1_FIRST, `RXA_E1_LAST} : {`RXA_SLOT_ZERO, `RXA_T1_LAST};
      rxa_pkg::RXA_UNCH: b = {`RXA_SLOT_ZERO, `RXA_UNCH_LAST};
      rxa_pkg::RXA_H2: b = {`RXA_SLOT_ZERO, `RXA_H2_LAST};
      rxa_pkg::RXA_H8: b = {`RXA_SLOT_ZERO, `RXA_H8_LAST};
    endcase
    return b;
  endfunction

  // Position of the bit after the given one, wrapping at the frame end.
  function automatic logic [9:0] advance(input logic [6:0] slot, input logic [2:0] bpos,
                                         input logic [6:0] lo, input logic [6:0] hi);
    logic [9:0] r;
    if (bpos != `RXA_BIT_LAST) begin
      r = {slot, 3'(bpos + 3'h1)};
    end else begin
      r = {(slot == hi) ? lo : 7'(slot + 7'h01), 3'h0};
    end
    return r;
  endfunction

  assign pins = {rx_highrate_frame_pulse_clock_i, rx_highrate_frame_pulse_n_i, rx_highrate_data_clock_i,
                 rx_group_frame_pulse_n_i, rx_group_data_clock_i, rx_line_data_i, rx_line_clock_i};
  assign s2 = st_reg.sy[1];
  assign s3 = st_reg.sy[2];
  assign cs2 = {s2[`RXA_SY_HFC], s2[`RXA_SY_HDC], s2[`RXA_SY_GCK +: `RXA_GROUPS], s2[`RXA_SY_CLK +: `RXA_LINKS]};
  assign cs3 = {s3[`RXA_SY_HFC], s3[`RXA_SY_HDC], s3[`RXA_SY_GCK +: `RXA_GROUPS], s3[`RXA_SY_CLK +: `RXA_LINKS]};
  // a link clock is resolved only while each half period spans two core cycles.
  // A clock level counts once stages two and three agree on a new value.
  assign chg = (cs2 ~^ cs3) & (cs3 ^ st_reg.lvl);
  assign rise = chg & cs3;
  assign fall = chg & ~cs3;
  assign grant = lowest(st_reg.pend);

  // Group and high-rate clock enables from the configured modes.
  for (genvar k = 0; k < `RXA_GROUPS; k++) begin : g_group_en
    // group k owns links 8k to 8k+7.
    assign g_en[k] = group_uses_h2(link_cfg_i[k * `RXA_GROUP_SIZE +: `RXA_GROUP_SIZE]);
  end

  always_comb begin
    hr_en = 1'b0;
    for (int m = 0; m < `RXA_LINKS; m += `RXA_HR_STEP) begin
      if (link_cfg_i[m].mode == rxa_pkg::RXA_H8) begin
        hr_en = 1'b1;
      end
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.sy = {st_reg.sy[1], st_reg.sy[0], pins};
    st_next.lvl = st_reg.lvl ^ chg;
    gsamp = '0;
    gfp_ev = '0;
    samp = '0;
    align = '0;
    gap = '0;
    first = '0;
    last = '0;

    // Group clocks: even rises sample, a low pulse on the fall restarts the phase.
    for (int k = 0; k < `RXA_GROUPS; k++) begin
      if (g_en[k] && rise[`RXA_ED_GCK + k]) begin
        gsamp[k] = st_reg.gph[k];
        st_next.gph[k] = ~st_reg.gph[k];
      end
      // frame pulse taken on the group clock fall.
      if (g_en[k] && fall[`RXA_ED_GCK + k] && !s3[`RXA_SY_GFP + k]) begin
        gfp_ev[k] = 1'b1;
        st_next.gph[k] = 1'b0;
      end
    end

    // high-rate data clock ignored with no high-rate link.
    hsamp = 1'b0;
    if (hr_en && rise[`RXA_ED_HDC]) begin
      hsamp = st_reg.hph;
      st_next.hph = ~st_reg.hph;
    end
    // high-rate frame pulse taken on the frame pulse clock fall.
    // frame pulse clock ignored with no high-rate link.
    hfp_ev = hr_en && fall[`RXA_ED_HFC] && !s3[`RXA_SY_HFP];
    if (hfp_ev) begin
      st_next.hph = 1'b0;
    end

    // lowest pending link wins; a new bit in the same cycle keeps it pending.
    st_next.out = '0;
    if (st_reg.pend != '0) begin
      st_next.out = {1'b1, grant, st_reg.pdat[grant], st_reg.pslot[grant], st_reg.pbpos[grant], st_reg.pfs[grant]};
      st_next.pend[grant] = 1'b0;
    end

    for (int n = 0; n < `RXA_LINKS; n++) begin
      {first[n], last[n]} = bounds(link_cfg_i[n]);
      // mode picks the sampling clock and alignment source.
      unique case (link_cfg_i[n].mode)
        rxa_pkg::RXA_CHAN, rxa_pkg::RXA_UNCH: begin
          samp[n] = rise[n];
          // an interval half again longer than the last marks the gap.
          gap[n] = (link_cfg_i[n].mode == rxa_pkg::RXA_CHAN) && rise[n] && (st_reg.ival[n] != 8'h00) &&
                   ({1'b0, st_reg.icnt[n]} > ({1'b0, st_reg.ival[n]} + {2'b00, st_reg.ival[n][7:1]}));
        end
        rxa_pkg::RXA_H2: begin
          // own link clock unused in H-MVIP.
          samp[n] = gsamp[n / `RXA_GROUP_SIZE];
          // group frame pulse aligns its eight links.
          align[n] = gfp_ev[n / `RXA_GROUP_SIZE];
        end
        rxa_pkg::RXA_H8: begin
          // only links 4m follow the high-rate clocks.
          samp[n] = (n % `RXA_HR_STEP == 0) && hsamp;
          align[n] = (n % `RXA_HR_STEP == 0) && hfp_ev;
        end
      endcase

      if (rise[n]) begin
        st_next.icnt[n] = 8'h00;
        if (!gap[n]) begin
          st_next.ival[n] = st_reg.icnt[n];
        end
      end else if (st_reg.icnt[n] != `RXA_ICNT_MAX) begin
        st_next.icnt[n] = 8'(st_reg.icnt[n] + 8'h01);
      end

      if (samp[n]) begin
        st_next.pend[n] = 1'b1;
        st_next.pdat[n] = s3[`RXA_SY_DAT + n];
        // A slot outside this mode's frame, as after reset on an E1 link, restarts at the first slot.
        st_next.pslot[n] = (gap[n] || st_reg.slot[n] < first[n] || st_reg.slot[n] > last[n]) ?
                           first[n] : st_reg.slot[n];
        st_next.pbpos[n] = gap[n] ? 3'h0 : st_reg.bpos[n];
        st_next.pfs[n] = gap[n] | st_reg.fsp[n];
        st_next.fsp[n] = 1'b0;
        {st_next.slot[n], st_next.bpos[n]} = advance(st_next.pslot[n], st_next.pbpos[n], first[n], last[n]);
      end
      if (align[n]) begin
        st_next.slot[n] = first[n];
        st_next.bpos[n] = 3'h0;
        st_next.fsp[n] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rx_bit_o = st_reg.out;

  default clocking a_clk @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_prio_pick: assert property (st_reg.pend != '0 |=> rx_bit_o.valid && rx_bit_o.link == lowest($past(st_reg.pend)))
    else $error("serviced link is not the lowest pending one");
  a_idle_quiet: assert property (st_reg.pend == '0 |=> !rx_bit_o.valid)
    else $error("bit handed out with nothing pending");
  a_slot_range: assert property (rx_bit_o.valid |-> rx_bit_o.slot >= first[rx_bit_o.link]
                                 && rx_bit_o.slot <= last[rx_bit_o.link])
    else $error("time-slot outside the frame of its mode");
  a_h8_only_4m: assert property (rx_bit_o.valid && link_cfg_i[rx_bit_o.link].mode == rxa_pkg::RXA_H8
                                 |-> rx_bit_o.link[1:0] == 2'h0)
    else $error("high-rate bit from a link not a multiple of four");
  a_gap_align: assert property (gap[0] |=> st_reg.pend[0] && st_reg.pfs[0] && st_reg.pbpos[0] == 3'h0
                                && st_reg.pslot[0] == $past(first[0]))
    else $error("gap did not realign link zero");
  a_hr_ignored: assert property (!hr_en |=> $stable(st_reg.hph))
    else $error("high-rate phase moved with no high-rate link");
  a_fp_restart: assert property (align[0] |=> st_reg.slot[0] == `RXA_SLOT_ZERO && st_reg.bpos[0] == 3'h0
                                 && st_reg.fsp[0])
    else $error("frame pulse did not restart link zero");
  a_fs_first_bit: assert property (rx_bit_o.valid && rx_bit_o.frame_start
                                   && link_cfg_i[rx_bit_o.link].mode inside {rxa_pkg::RXA_H2, rxa_pkg::RXA_H8}
                                   |-> rx_bit_o.slot == `RXA_SLOT_ZERO && rx_bit_o.bitpos == 3'h0)
    else $error("H-MVIP frame start not on slot zero bit zero");
  a_grp_ignored: assert property (!g_en[0] |=> $stable(st_reg.gph[0]))
    else $error("group clock acted with no low-rate link in group");
  a_every_second: assert property (g_en[0] && rise[`RXA_ED_GCK] |=> st_reg.gph[0] != $past(st_reg.gph[0]))
    else $error("group phase did not alternate on a counted rise");

endmodule // rxa_top
